// [hw/diag_status_and_coeff_upload_regs.sv]
// diagnostic status and filter tap upload register bank
// assumes a serial front end on mclk presents register accesses and link events
`timescale 1ns/10ps
`include "diag_regs_consts.svh"
module diag_status_and_coeff_upload_regs
  import diag_regs_pkg::*;
#(
  parameter logic [7:0] UNLOCK_KEY = `UNLOCK_KEY_DEFAULT,
  parameter int TAPS = `TAP_COUNT
) (
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // register access
  input wire reg_req_t req,
  output logic [23:0] rdata,
  // link error events and enables
  input wire link_events_t linkEv,
  input wire logic [7:0] linkErrEnable,
  // converter and integrity sources (async)
  input wire logic [5:0] convDiagIn,
  input wire logic [2:0] integDiagIn,
  // filter side
  input wire logic syncPulse,
  input wire logic [5:0] tapRdIndex,
  output logic [22:0] tapRdValue,
  output logic keepUserTaps,
  output logic reloadDefaults,
  output logic clockQualifyFail
);
  // ********************
  // reset release
  // ********************
  logic rstMeta, rstSync;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end
  initial begin
    if (TAPS < 1 || TAPS > 64) $error("tap count must fit the 6-bit index");
  end
  // ********************
  // input synchronisers
  // ********************
  logic [8:0] diagMeta, diagSync;
  always_ff @(posedge mclk or negedge rstSync) begin
    if (!rstSync) begin
      diagMeta <= '0;
      diagSync <= '0;
    end else begin
      diagMeta <= {integDiagIn, convDiagIn};
      diagSync <= diagMeta;
    end
  end
  // ********************
  // link error flags
  // ********************
  logic [7:0] linkErr_reg;
  logic wrLink, wrCtrl, wrValue, wrKey;
  assign wrLink = req.wr && req.addr == `OFS_LINK_ERR;
  assign wrCtrl = req.wr && req.addr == `OFS_TAP_CTRL;
  assign wrValue = req.wr && req.addr == `OFS_TAP_VALUE;
  assign wrKey = req.wr && req.addr == `OFS_UNLOCK;
  logic [4:0] evVec, clrVec;
  always_comb begin
    evVec = '0;
    evVec[`BIT_IGNORE] = linkEv.ignoreErr && linkErrEnable[`BIT_IGNORE];
    evVec[`BIT_BITCOUNT] = linkEv.bitcountErr && linkEv.framed && linkErrEnable[`BIT_BITCOUNT];
    evVec[`BIT_RDERR] = linkEv.readErr && linkErrEnable[`BIT_RDERR];
    evVec[`BIT_WRERR] = linkEv.writeErr && linkErrEnable[`BIT_WRERR];
    evVec[`BIT_CRCERR] = linkEv.crcErr;
    clrVec = wrLink ? req.wdata[4:0] : '0;
    clrVec[`BIT_BITCOUNT] = 1'b0;
  end
  always_ff @(posedge mclk or negedge rstSync) begin
    if (!rstSync) begin
      linkErr_reg <= 8'h00;
    end else begin
      linkErr_reg[4:0] <= (linkErr_reg[4:0] & ~clrVec) | evVec;
    end
  end
  // ********************
  // tick counter
  // ********************
  logic tick;
  logic [7:0] ticks_reg;
  tick_divider #(.DIV(`TICK_DIVIDE)) u_div (
    .mclk(mclk),
    .arst_n(rstSync),
    .tick(tick)
  );
  always_ff @(posedge mclk or negedge rstSync) begin
    if (!rstSync) ticks_reg <= 8'h00;
    else if (tick) ticks_reg <= ticks_reg + 8'h01;
  end
  // ********************
  // tap control and unlock
  // ********************
  logic [7:0] tapCtrl_reg;
  logic [23:0] tapValue_reg;
  logic keyOk_reg;
  always_ff @(posedge mclk or negedge rstSync) begin
    if (!rstSync) begin
      tapCtrl_reg <= 8'h00;
      tapValue_reg <= 24'h00_0000;
      keyOk_reg <= 1'b0;
    end else begin
      if (wrCtrl) tapCtrl_reg <= req.wdata[7:0];
      if (wrValue) tapValue_reg <= req.wdata;
      if (wrKey) keyOk_reg <= (req.wdata[7:0] == UNLOCK_KEY);
    end
  end
  upload_state_t upState;
  always_comb begin
    if (!keyOk_reg || !tapCtrl_reg[`BIT_ACCESS_EN]) upState = UP_LOCKED;
    else if (tapCtrl_reg[`BIT_WRITE_EN]) upState = UP_WRITING;
    else upState = UP_OPEN;
  end
  // ********************
  // tap memory
  // ********************
  logic [22:0] taps [TAPS];
  logic [5:0] tapIdx;
  logic [22:0] tapAtIdx;
  assign tapIdx = tapCtrl_reg[5:0];
  assign tapAtIdx = taps[tapIdx];
  always_ff @(posedge mclk) begin
    case (upState)
      UP_WRITING: begin
        if (wrValue && tapIdx < 6'(TAPS)) taps[tapIdx] <= req.wdata[22:0];
      end
      default: begin
      end
    endcase
  end
  always_ff @(posedge mclk or negedge rstSync) begin
    if (!rstSync) begin
      tapRdValue <= '0;
      keepUserTaps <= 1'b0;
      reloadDefaults <= 1'b0;
      clockQualifyFail <= 1'b0;
    end else begin
      tapRdValue <= (tapRdIndex < 6'(TAPS)) ? taps[tapRdIndex] : '0;
      keepUserTaps <= tapValue_reg[`BIT_KEEP_TAPS];
      reloadDefaults <= syncPulse && !tapValue_reg[`BIT_KEEP_TAPS];
      clockQualifyFail <= diagSync[0];
    end
  end
  // ********************
  // read mux
  // ********************
  always_ff @(posedge mclk or negedge rstSync) begin
    if (!rstSync) begin
      rdata <= 24'h00_0000;
    end else if (req.rd) begin
      case (req.addr)
        `OFS_LINK_ERR: rdata <= {16'h0000, linkErr_reg};
        `OFS_CONV_DIAG: rdata <= {16'h0000, 2'b00, diagSync[5:0]};
        `OFS_INTEG: rdata <= {16'h0000, 3'b000, diagSync[8:6], 2'b00};
        `OFS_TICKS: rdata <= {16'h0000, ticks_reg};
        `OFS_TAP_CTRL: rdata <= {16'h0000, tapCtrl_reg};
        `OFS_TAP_VALUE: begin
          if (upState != UP_LOCKED && tapIdx < 6'(TAPS)) rdata <= {tapValue_reg[23], taps[tapIdx]};
          else rdata <= tapValue_reg;
        end
        `OFS_UNLOCK: rdata <= {23'h00_0000, keyOk_reg};
        default: rdata <= 24'h00_0000;
      endcase
    end
  end
  // ********************
  // checks
  // ********************
  property p_bitcount_kept;
    @(posedge mclk) disable iff (!rstSync)
    linkErr_reg[`BIT_BITCOUNT] |=> linkErr_reg[`BIT_BITCOUNT];
  endproperty
  a_bitcount_kept: assert property (p_bitcount_kept) else $error("bit-count flag cleared");
  property p_w1c;
    @(posedge mclk) disable iff (!rstSync)
    (wrLink && req.wdata[`BIT_RDERR] && !evVec[`BIT_RDERR]) |=> !linkErr_reg[`BIT_RDERR];
  endproperty
  a_w1c: assert property (p_w1c) else $error("read flag not cleared");
  property p_set_wins;
    @(posedge mclk) disable iff (!rstSync)
    evVec[`BIT_WRERR] |=> linkErr_reg[`BIT_WRERR];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("write flag lost");
  property p_tick;
    @(posedge mclk) disable iff (!rstSync)
    tick |=> !tick [*8];
  endproperty
  a_tick: assert property (p_tick) else $error("tick too frequent");
  property p_count;
    @(posedge mclk) disable iff (!rstSync)
    tick |=> ticks_reg == $past(ticks_reg) + 8'h01;
  endproperty
  a_count: assert property (p_count) else $error("counter did not step");
  property p_locked_write;
    @(posedge mclk) disable iff (!rstSync)
    (wrValue && tapIdx < 6'(TAPS)
      && !(keyOk_reg && tapCtrl_reg[`BIT_ACCESS_EN] && tapCtrl_reg[`BIT_WRITE_EN]))
      |=> $stable(tapAtIdx);
  endproperty
  a_locked_write: assert property (p_locked_write) else $error("tap memory written while locked");
  property p_key;
    @(posedge mclk) disable iff (!rstSync)
    wrKey |=> keyOk_reg == ($past(req.wdata[7:0]) == UNLOCK_KEY);
  endproperty
  a_key: assert property (p_key) else $error("key compare wrong");
  property p_reload;
    @(posedge mclk) disable iff (!rstSync)
    (syncPulse && tapValue_reg[`BIT_KEEP_TAPS]) |=> !reloadDefaults;
  endproperty
  a_reload: assert property (p_reload) else $error("defaults reloaded over user taps");
endmodule : diag_status_and_coeff_upload_regs

// [hw/diag_regs_consts.svh]
// constants for the diagnostic status and tap upload register bank
// assumes a 24-bit register access port decoded by the serial front end
// How it works
// - ignore, read, write, checksum flags clear-on-one
// - bit-count flag read-only, writes cannot clear
// - converter diagnostic flags read-only, reset zero
// - clock qualify flag bit0, to status and to clockQualifyFail
// - integrity checksum flags bits 4..2, rest zero
// - 8-bit counter steps every 64 clocks
// - memory access only with access enable set
// - memory writes only with write enable set
// - tap index 0..55, host avoids others
// - keep user taps bit survives sync
// - tap value from data bits 22..0
// - key bit reads one after correct key
// - link flags except checksum set only when enabled
// - bit-count error only for framed transactions
`ifndef DIAG_REGS_CONSTS_SVH
`define DIAG_REGS_CONSTS_SVH
// ********************
// offsets
// ********************
`define OFS_LINK_ERR 7'h2E
`define OFS_CONV_DIAG 7'h2F
`define OFS_INTEG 7'h30
`define OFS_TICKS 7'h31
`define OFS_TAP_CTRL 7'h32
`define OFS_TAP_VALUE 7'h33
`define OFS_UNLOCK 7'h34
// ********************
// fields and values
// ********************
`define BIT_IGNORE 4
`define BIT_BITCOUNT 3
`define BIT_RDERR 2
`define BIT_WRERR 1
`define BIT_CRCERR 0
`define BIT_ACCESS_EN 7
`define BIT_WRITE_EN 6
`define BIT_KEEP_TAPS 23
`define LINK_EN_RESET 8'h10
`define TAP_COUNT 56
`define TICK_DIVIDE 64
`define UNLOCK_KEY_DEFAULT 8'h5A
`endif

// [hw/diag_regs_pkg.sv]
// types shared by the register bank
// assumes the constants header is compiled alongside
package diag_regs_pkg;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [6:0] addr;
    logic [23:0] wdata;
  } reg_req_t;
  typedef struct packed {
    logic ignoreErr;
    logic bitcountErr;
    logic readErr;
    logic writeErr;
    logic crcErr;
    logic framed;
  } link_events_t;
  typedef enum logic [1:0] {UP_LOCKED, UP_OPEN, UP_WRITING} upload_state_t;
endpackage : diag_regs_pkg

// [hw/tick_divider.sv]
// divider producing a one-cycle enable every DIV clocks
// assumes a synchronous-release reset
`timescale 1ns/10ps
module tick_divider #(
  parameter int DIV = 64
) (
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // enable out
  output logic tick
);
  localparam int W = $clog2(DIV);
  logic [W-1:0] cnt_reg;
  initial begin
    if (DIV < 2) $error("divide must be at least two");
  end
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= '0;
      tick <= 1'b0;
    end else begin
      tick <= (cnt_reg == W'(DIV - 1));
      cnt_reg <= (cnt_reg == W'(DIV - 1)) ? '0 : cnt_reg + 1'b1;
    end
  end
endmodule : tick_divider

// [sim/host_link_model.sv]
// host controller model: register accesses, unlock and sync pulses
// assumes the bench clock; drives 1 ns after the rising edge
`timescale 1ns/10ps
`include "diag_regs_consts.svh"
module host_link_model
  import diag_regs_pkg::*;
#(
  parameter logic [7:0] KEY = `UNLOCK_KEY_DEFAULT
) (
  // clock
  input wire logic mclk,
  // register access
  output reg_req_t req,
  input wire logic [23:0] rdata,
  // filter side
  output logic syncPulse
);
  initial begin
    req = '0;
    syncPulse = 1'b0;
  end
  // idle bus shows inverted values, not the last ones
  task automatic wr(input logic [6:0] a, input logic [23:0] d);
    @(posedge mclk) #1;
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge mclk) #1;
    req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask : wr
  task automatic rd(input logic [6:0] a, output logic [23:0] d);
    @(posedge mclk) #1;
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: ~req.wdata};
    @(posedge mclk) #1;
    req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~req.wdata};
    @(posedge mclk) #1;
    d = rdata;
  endtask : rd
  task automatic unlock();
    wr(`OFS_UNLOCK, {16'h0000, KEY});
  endtask : unlock
  task automatic sync();
    @(posedge mclk) #1;
    syncPulse = 1'b1;
    @(posedge mclk) #1;
    syncPulse = 1'b0;
  endtask : sync
endmodule : host_link_model

// [sim/diag_status_and_coeff_upload_regs_tb_top.sv]
// bench for the diagnostic status and tap upload register bank
// assumes host_link_model as the far side; 4 ns clock
`timescale 1ns/10ps
`include "diag_regs_consts.svh"
module diag_status_and_coeff_upload_regs_tb_top;
  import diag_regs_pkg::*;
  logic mclk, arst_n, syncPulse, keepUserTaps, reloadDefaults, clockQualifyFail;
  reg_req_t req;
  logic [23:0] rdata, rv;
  link_events_t linkEv;
  logic [7:0] linkErrEnable, cnt;
  logic [5:0] convDiagIn, tapRdIndex;
  logic [2:0] integDiagIn;
  logic [22:0] tapRdValue;
  int failCount, checksDone, cyc, pulses;
  diag_status_and_coeff_upload_regs i_diag_status_and_coeff_upload_regs (.mclk(mclk), .arst_n(arst_n),
    .req(req), .rdata(rdata), .linkEv(linkEv), .linkErrEnable(linkErrEnable), .convDiagIn(convDiagIn),
    .integDiagIn(integDiagIn), .syncPulse(syncPulse), .tapRdIndex(tapRdIndex), .tapRdValue(tapRdValue),
    .keepUserTaps(keepUserTaps), .reloadDefaults(reloadDefaults), .clockQualifyFail(clockQualifyFail));
  host_link_model i_host_link_model (.mclk(mclk), .req(req), .rdata(rdata), .syncPulse(syncPulse));
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checksDone, failCount);
    if (failCount == 0 && checksDone > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string m);
    checksDone++;
    if (got !== exp) begin
      failCount++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic rdchk(input logic [6:0] a, input logic [23:0] exp);
    i_host_link_model.rd(a, rv);
    chk(rv, exp, "read");
  endtask : rdchk
  task automatic ev(input logic [5:0] e);
    @(posedge mclk) #1;
    linkEv = e;
    @(posedge mclk) #1;
    linkEv = '0;
  endtask : ev
  task automatic tapchk(input logic [5:0] i, input logic [23:0] exp);
    tapRdIndex = i;
    repeat (3) @(posedge mclk);
    #1;
    chk({1'b0, tapRdValue}, exp, "tap");
  endtask : tapchk
  task automatic syncchk(input int exp);
    pulses = 0;
    fork
      i_host_link_model.sync();
      repeat (5) @(posedge mclk) #1 pulses += int'(reloadDefaults);
    join
    chk(24'(pulses), 24'(exp), "reload");
  endtask : syncchk
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      failCount++;
      end_sim();
    end
  end
  initial begin
    arst_n = 1'b0;
    linkEv = '0;
    linkErrEnable = 8'h00;
    convDiagIn = 6'h00;
    integDiagIn = 3'h0;
    tapRdIndex = 6'h00;
    repeat (5) @(posedge mclk);
    #1 arst_n = 1'b1;
    repeat (4) @(posedge mclk);
    // ********************
    // reset values, unmapped
    // ********************
    for (int a = 'h2E; a <= 'h35; a++) begin
      rdchk(7'(a), 24'h00_0000);
    end
    // ********************
    // link error flags
    // ********************
    ev(6'h3D);
    rdchk(`OFS_LINK_ERR, 24'h00_0000);
    linkErrEnable = 8'h1E;
    ev(6'h10);
    rdchk(`OFS_LINK_ERR, 24'h00_0000);
    ev(6'h3F);
    rdchk(`OFS_LINK_ERR, 24'h00_001F);
    i_host_link_model.wr(`OFS_LINK_ERR, 24'h00_001F);
    rdchk(`OFS_LINK_ERR, 24'h00_0008);
    // ********************
    // diagnostics and counter
    // ********************
    convDiagIn = 6'h3F;
    integDiagIn = 3'h7;
    repeat (4) @(posedge mclk);
    rdchk(`OFS_CONV_DIAG, 24'h00_003F);
    chk({23'h0, clockQualifyFail}, 24'h00_0001, "clkq");
    rdchk(`OFS_INTEG, 24'h00_001C);
    i_host_link_model.rd(`OFS_TICKS, rv);
    cnt = rv[7:0] + 8'h02;
    repeat (125) @(posedge mclk);
    rdchk(`OFS_TICKS, {16'h0000, cnt});
    // ********************
    // tap upload
    // ********************
    i_host_link_model.wr(`OFS_UNLOCK, 24'h00_0000);
    rdchk(`OFS_UNLOCK, 24'h00_0000);
    i_host_link_model.unlock();
    rdchk(`OFS_UNLOCK, 24'h00_0001);
    i_host_link_model.wr(`OFS_TAP_CTRL, 24'h00_00C5);
    i_host_link_model.wr(`OFS_TAP_VALUE, 24'h00_0123);
    tapchk(6'h05, 24'h00_0123);
    i_host_link_model.wr(`OFS_TAP_CTRL, 24'h00_0085);
    i_host_link_model.wr(`OFS_TAP_VALUE, 24'h00_0456);
    tapchk(6'h05, 24'h00_0123);
    rdchk(`OFS_TAP_VALUE, 24'h00_0123);
    i_host_link_model.wr(`OFS_TAP_CTRL, 24'h00_0045);
    i_host_link_model.wr(`OFS_TAP_VALUE, 24'h00_0789);
    tapchk(6'h05, 24'h00_0123);
    rdchk(`OFS_TAP_VALUE, 24'h00_0789);
    i_host_link_model.wr(`OFS_UNLOCK, 24'h00_0000);
    i_host_link_model.wr(`OFS_TAP_CTRL, 24'h00_00C5);
    i_host_link_model.wr(`OFS_TAP_VALUE, 24'h00_0ABC);
    tapchk(6'h05, 24'h00_0123);
    i_host_link_model.unlock();
    i_host_link_model.wr(`OFS_TAP_CTRL, 24'h00_00F7);
    i_host_link_model.wr(`OFS_TAP_VALUE, 24'h7F_FFFF);
    tapchk(6'd55, 24'h7F_FFFF);
    tapchk(6'd56, 24'h00_0000);
    chk({23'h0, keepUserTaps}, 24'h00_0000, "keep");
    syncchk(1);
    i_host_link_model.wr(`OFS_TAP_VALUE, 24'hFF_FFFF);
    @(posedge mclk) #1;
    chk({23'h0, keepUserTaps}, 24'h00_0001, "keep");
    syncchk(0);
    end_sim();
  end
endmodule : diag_status_and_coeff_upload_regs_tb_top
